// >>> src/smb_pkg.sv
// Constants, register map and types of the supply monitor and booster control block
// How it works
// - Two select bits pick one of four thresholds
// - Flag reads one when supply below threshold
// - Flag reads zero while detector is stopped
// - Flag is read-only, writes ignored
// - Enable bit powers detector, reset clears it
// - Reset clears both threshold select bits
// - Reset sets booster select bit to one
// - Writing zero releases and stops the booster
// - Time-base reset forces plain; booster 62.5 ms after system reset release
// - Booster off returns boosted output to plain
// - Logic supply: plain, regulated, or boosted with oscillator
// - Bias reference plain in reset, then contrast
`default_nettype none
package smb_pkg;
    // Register indices; byte address is four times the index
    localparam logic [11:0] SMC_IDX = 12'h094;
    localparam logic [11:0] BOOST_IDX = 12'h095;
    localparam logic [11:0] STAT_IDX = 12'h098;
    localparam logic [11:0] MASK_IDX = 12'h099;
    localparam logic [11:0] PWR_IDX = 12'h09a;
    localparam int ADDR_W = 14;

    // supply_monitor_control fields
    localparam int SMC_FLAG_BIT = 3;
    localparam int SMC_EN_BIT = 2;
    localparam int SMC_SEL_HI = 1;
    localparam int SMC_SEL_LO = 0;
    localparam logic [3:0] SMC_RESET = 4'h0;

    // booster_control: bit 0 selects the booster, bits 3:1 read as one
    localparam int BOOST_BIT = 0;
    localparam logic BOOST_RESET = 1'b1;
    localparam logic [2:0] BOOST_UNUSED = 3'h7;

    // Power config: contrast in 3:0, fast oscillator enable in 4
    localparam int PWR_OSC_BIT = 4;
    localparam logic [4:0] PWR_RESET = 5'h00;

    // Interrupt status / mask layout
    localparam int IRQ_W = 3;
    localparam int IRQ_LOW = 0;
    localparam int IRQ_SETTLED = 1;
    localparam int IRQ_BOOST = 2;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Detection thresholds in millivolts, indexed by the select field
    localparam logic [11:0] THR_MV [4] = '{12'd1050, 12'd1200, 12'd1800, 12'd2400};

    // Timing
    localparam int CLK_HZ = 250_000_000;
    localparam int SETTLE_MS = 1;
    localparam int SETTLE_CYC = SETTLE_MS * (CLK_HZ / 1000);
    localparam int BOOST_DELAY_US = 62_500; // 62.5 ms
    localparam int BOOST_DELAY_CYC = BOOST_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W = 24;

    // Booster sequencing states
    typedef enum logic [2:0] {
        BST_HOLD = 3'h1,
        BST_RUN = 3'h2,
        BST_OFF = 3'h4
    } smb_bst_state_t;

    // Source of the internal-logic supply
    typedef enum logic [1:0] {
        LOGIC_PLAIN = 2'h0,
        LOGIC_REG = 2'h1,
        LOGIC_BOOST = 2'h2
    } smb_logic_src_t;

    // Register index to byte address
    function automatic logic [ADDR_W-1:0] regAddr(input logic [11:0] idx);
        regAddr = {idx, 2'b00};
    endfunction
endpackage
`default_nettype wire

// >>> src/smb_sync.sv
// Two-flop synchroniser for the asynchronous comparator output
`default_nettype none
module smb_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic din,
    output logic dout
);
    logic meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end

    sync_lat_a: assert property (@(posedge clk) disable iff (!rst_n)
        ##2 1'b1 |-> dout == $past(din, 2)) else $error("synchroniser latency wrong");
endmodule // smb_sync
`default_nettype wire

// >>> src/smb_ctrl.sv
// Supply monitor and booster control with AXI4-Lite register access
//
// Chosen here: the AXI4-Lite interface to the registers.
`default_nettype none
module smb_ctrl #(
    parameter int BOOST_DELAY_CYC = smb_pkg::BOOST_DELAY_CYC,
    parameter int SETTLE_CYC = smb_pkg::SETTLE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AXI4-Lite write address and data
    input wire logic [smb_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [smb_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Analog side inputs
    input wire logic cmpLow,
    input wire logic timeBaseReset,
    // Analog side controls
    output logic monitorOn,
    output logic [1:0] thresholdSel,
    output logic boostedSupplySel,
    output logic [1:0] logicSupplySel,
    output logic biasRefPlain,
    output logic [3:0] biasContrast,
    // Interrupt
    output logic irq
);
    // Register state
    logic monitorEnable_r;
    logic [1:0] thresholdSel_r;
    logic boosterSelect_r;
    logic [4:0] powerConfig_r;
    logic [smb_pkg::IRQ_W-1:0] irqStat_r;
    logic [smb_pkg::IRQ_W-1:0] irqMask_r;
    // Bus state
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    // Monitor and booster state
    logic cmpLowSync;
    logic lowFlag;
    logic lowFlagPrev_r;
    logic [smb_pkg::CNT_W-1:0] settleCnt_r;
    logic settled_r;
    logic [smb_pkg::CNT_W-1:0] bootCnt_r;
    logic bootDone_r;
    smb_pkg::smb_bst_state_t bstState_r;
    smb_pkg::smb_bst_state_t bstState_nxt;
    logic boosted_r;
    smb_pkg::smb_logic_src_t logicSrc_r;
    logic biasPlain_r;
    logic irq_r;
    // Decode helpers
    localparam int IRQ_LAST = smb_pkg::IRQ_W - 1;
    logic wrEn;
    logic rdEn;
    logic wrLane;
    logic [IRQ_LAST:0] evt;
    logic [31:0] rdMux;
    logic rdHit;

    // Comparator is asynchronous to clk
    smb_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din(cmpLow),
        .dout(cmpLowSync)
    );

    // Flag is forced low while the detector is off
    assign lowFlag = monitorEnable_r & cmpLowSync;

    // Accept address and data together, one write at a time
    assign wrEn = s_axi_awvalid & awready_r & s_axi_wvalid & wready_r;
    assign wrLane = s_axi_wstrb[0];
    assign rdEn = s_axi_arvalid & arready_r;

    // Write channel handshake; a new write waits for the response to drain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= smb_pkg::RESP_OKAY;
        end else begin
            awready_r <= s_axi_awvalid & s_axi_wvalid & ~awready_r & ~bvalid_r;
            wready_r <= s_axi_awvalid & s_axi_wvalid & ~awready_r & ~bvalid_r;
            if (wrEn) begin
                bvalid_r <= 1'b1;
                bresp_r <= isMapped(s_axi_awaddr) ? smb_pkg::RESP_OKAY : smb_pkg::RESP_DECERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Mapped-address check, used by the write channel only; reads decode in the read mux
    function automatic logic isMapped(input logic [smb_pkg::ADDR_W-1:0] a);
        isMapped = (a == smb_pkg::regAddr(smb_pkg::SMC_IDX)) || (a == smb_pkg::regAddr(smb_pkg::BOOST_IDX))
            || (a == smb_pkg::regAddr(smb_pkg::STAT_IDX)) || (a == smb_pkg::regAddr(smb_pkg::MASK_IDX))
            || (a == smb_pkg::regAddr(smb_pkg::PWR_IDX));
    endfunction

    // Monitor control; the flag bit has no storage so writes cannot reach it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            monitorEnable_r <= smb_pkg::SMC_RESET[smb_pkg::SMC_EN_BIT];
            thresholdSel_r <= smb_pkg::SMC_RESET[smb_pkg::SMC_SEL_HI:smb_pkg::SMC_SEL_LO];
        end else if (wrEn && wrLane && s_axi_awaddr == smb_pkg::regAddr(smb_pkg::SMC_IDX)) begin
            monitorEnable_r <= s_axi_wdata[smb_pkg::SMC_EN_BIT];
            thresholdSel_r <= s_axi_wdata[smb_pkg::SMC_SEL_HI:smb_pkg::SMC_SEL_LO];
        end
    end

    // Booster select comes up set so the booster is on by default
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boosterSelect_r <= smb_pkg::BOOST_RESET;
        end else if (wrEn && wrLane && s_axi_awaddr == smb_pkg::regAddr(smb_pkg::BOOST_IDX)) begin
            boosterSelect_r <= s_axi_wdata[smb_pkg::BOOST_BIT];
        end
    end

    // Display contrast and fast oscillator enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            powerConfig_r <= smb_pkg::PWR_RESET;
        end else if (wrEn && wrLane && s_axi_awaddr == smb_pkg::regAddr(smb_pkg::PWR_IDX)) begin
            powerConfig_r <= s_axi_wdata[4:0];
        end
    end

    // Interrupt mask
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqMask_r <= smb_pkg::IRQ_RESET;
        end else if (wrEn && wrLane && s_axi_awaddr == smb_pkg::regAddr(smb_pkg::MASK_IDX)) begin
            irqMask_r <= s_axi_wdata[IRQ_LAST:0];
        end
    end

    // Settling timer: counts only while enabled, restarts on every enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            settleCnt_r <= '0;
            settled_r <= 1'b0;
        end else if (!monitorEnable_r) begin
            settleCnt_r <= '0;
            settled_r <= 1'b0;
        end else if (!settled_r) begin
            settleCnt_r <= settleCnt_r + 1'b1;
            settled_r <= (settleCnt_r == smb_pkg::CNT_W'(SETTLE_CYC - 1));
        end
    end

    // Edge history for the low-supply event
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lowFlagPrev_r <= 1'b0;
        end else begin
            lowFlagPrev_r <= lowFlag;
        end
    end

    // Events: low supply once settled, settling done, booster running
    always_comb begin
        evt = '0;
        evt[smb_pkg::IRQ_LOW] = settled_r & lowFlag & ~lowFlagPrev_r;
        evt[smb_pkg::IRQ_SETTLED] = monitorEnable_r & ~settled_r
            & (settleCnt_r == smb_pkg::CNT_W'(SETTLE_CYC - 1));
        evt[smb_pkg::IRQ_BOOST] = (bstState_nxt == smb_pkg::BST_RUN) & (bstState_r != smb_pkg::BST_RUN);
    end

    // Sticky status, write one to clear; a same-cycle event wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqStat_r <= smb_pkg::IRQ_RESET;
        end else if (wrEn && wrLane && s_axi_awaddr == smb_pkg::regAddr(smb_pkg::STAT_IDX)) begin
            irqStat_r <= (irqStat_r & ~s_axi_wdata[IRQ_LAST:0]) | evt;
        end else begin
            irqStat_r <= irqStat_r | evt;
        end
    end

    // Interrupt line, registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irqStat_r & irqMask_r);
        end
    end

    // Start-up delay from system reset release; saturates
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bootCnt_r <= '0;
            bootDone_r <= 1'b0;
        end else if (!bootDone_r) begin
            bootCnt_r <= bootCnt_r + 1'b1;
            bootDone_r <= (bootCnt_r == smb_pkg::CNT_W'(BOOST_DELAY_CYC - 1));
        end
    end

    // Booster sequencing: release beats hold, hold beats run
    always_comb begin
        if (!boosterSelect_r) begin
            bstState_nxt = smb_pkg::BST_OFF;
        end else if (timeBaseReset || !bootDone_r) begin
            bstState_nxt = smb_pkg::BST_HOLD;
        end else begin
            bstState_nxt = smb_pkg::BST_RUN;
        end
    end

    // State register and boosted-supply select
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bstState_r <= smb_pkg::BST_HOLD;
            boosted_r <= 1'b0;
        end else begin
            bstState_r <= bstState_nxt;
            case (bstState_nxt)
                smb_pkg::BST_RUN: begin
                    boosted_r <= 1'b1;
                end
                default: begin
                    boosted_r <= 1'b0; // Hold and off both mean plain
                end
            endcase
        end
    end

    // Logic supply and bias reference selection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            logicSrc_r <= smb_pkg::LOGIC_PLAIN;
            biasPlain_r <= 1'b1;
        end else begin
            biasPlain_r <= timeBaseReset;
            if (timeBaseReset) begin
                logicSrc_r <= smb_pkg::LOGIC_PLAIN;
            end else if (powerConfig_r[smb_pkg::PWR_OSC_BIT]) begin
                logicSrc_r <= smb_pkg::LOGIC_BOOST;
            end else begin
                logicSrc_r <= smb_pkg::LOGIC_REG;
            end
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdMux = '0;
        rdHit = 1'b1;
        case (s_axi_araddr)
            smb_pkg::regAddr(smb_pkg::SMC_IDX): begin
                rdMux[3:0] = {lowFlag, monitorEnable_r, thresholdSel_r};
            end
            smb_pkg::regAddr(smb_pkg::BOOST_IDX): begin
                rdMux[3:0] = {smb_pkg::BOOST_UNUSED, boosterSelect_r};
            end
            smb_pkg::regAddr(smb_pkg::STAT_IDX): begin
                rdMux[IRQ_LAST:0] = irqStat_r;
            end
            smb_pkg::regAddr(smb_pkg::MASK_IDX): begin
                rdMux[IRQ_LAST:0] = irqMask_r;
            end
            smb_pkg::regAddr(smb_pkg::PWR_IDX): begin
                rdMux[4:0] = powerConfig_r;
            end
            default: begin
                rdHit = 1'b0;
            end
        endcase
    end

    // Read channel: one cycle of arready, data the cycle after
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= smb_pkg::RESP_OKAY;
        end else begin
            arready_r <= s_axi_arvalid & ~arready_r & ~rvalid_r;
            if (rdEn) begin
                rvalid_r <= 1'b1;
                rdata_r <= rdMux;
                rresp_r <= rdHit ? smb_pkg::RESP_OKAY : smb_pkg::RESP_DECERR;
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // Outputs straight from flops
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign monitorOn = monitorEnable_r;
    assign thresholdSel = thresholdSel_r;
    assign boostedSupplySel = boosted_r;
    assign logicSupplySel = logicSrc_r;
    assign biasRefPlain = biasPlain_r;
    assign biasContrast = powerConfig_r[3:0];
    assign irq = irq_r;

    // Checks
    sequence smcWrite;
        wrEn && wrLane && s_axi_awaddr == smb_pkg::regAddr(smb_pkg::SMC_IDX);
    endsequence

    sequence boostRelease;
        wrEn && wrLane && s_axi_awaddr == smb_pkg::regAddr(smb_pkg::BOOST_IDX) && !s_axi_wdata[0];
    endsequence

    thr_select_a: assert property (@(posedge clk) disable iff (!rst_n)
        smcWrite |=> thresholdSel == $past(s_axi_wdata[1:0])) else $error("threshold select not taken");
    mon_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
        smcWrite |=> monitorOn == $past(s_axi_wdata[2])) else $error("monitor enable not taken");
    // Comparator pin seen three edges back: two sync stages plus the read capture
    flag_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        rdEn && s_axi_araddr == smb_pkg::regAddr(smb_pkg::SMC_IDX)
        |=> s_axi_rdata[3] == ($past(monitorOn) && $past(cmpLow, 3))) else $error("flag read wrong");
    flag_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        rdEn && !monitorEnable_r && s_axi_araddr == smb_pkg::regAddr(smb_pkg::SMC_IDX)
        |=> !s_axi_rdata[3]) else $error("flag set while detector off");
    flag_ro_a: assert property (@(posedge clk) disable iff (!rst_n)
        smcWrite and (s_axi_wdata[3] && !s_axi_wdata[2]) |=> !lowFlag) else $error("flag was writable");
    boost_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        timeBaseReset || !bootDone_r |=> !boostedSupplySel) else $error("boost during hold");
    boost_release_a: assert property (@(posedge clk) disable iff (!rst_n)
        boostRelease |-> ##2 !boostedSupplySel) else $error("booster not released");
    boost_return_a: assert property (@(posedge clk) disable iff (!rst_n)
        !boosterSelect_r |=> !boostedSupplySel) else $error("boosted output not returned");
    logic_src_a: assert property (@(posedge clk) disable iff (!rst_n)
        !timeBaseReset && powerConfig_r[smb_pkg::PWR_OSC_BIT]
        |=> logicSupplySel == smb_pkg::LOGIC_BOOST) else $error("logic supply not boosted");
    bias_plain_a: assert property (@(posedge clk) disable iff (!rst_n)
        timeBaseReset |=> biasRefPlain) else $error("bias not forced plain");
endmodule // smb_ctrl
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the supply monitor and booster control block
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 20000;
    localparam logic [13:0] A_SMC = {smb_pkg::SMC_IDX, 2'b00};
    localparam logic [13:0] A_BST = {smb_pkg::BOOST_IDX, 2'b00};
    localparam logic [13:0] A_STAT = {smb_pkg::STAT_IDX, 2'b00};
    localparam logic [13:0] A_MASK = {smb_pkg::MASK_IDX, 2'b00};
    localparam logic [13:0] A_PWR = {smb_pkg::PWR_IDX, 2'b00};
    localparam logic [13:0] A_NONE = 14'h3ffc;
    // Bench drive and design outputs
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [13:0] awAddr = 14'h0, arAddr = 14'h0;
    logic [31:0] wData = 32'h0, rData;
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic awReady, wReady, bValid, arReady, rValid;
    logic [1:0] bResp, rResp, thrSel, logicSel;
    logic cmpLow = 1'b0, tbReset = 1'b1;
    logic monOn, boostSel, biasPlain, irq;
    logic [3:0] contrast;
    logic [31:0] rd;
    logic [1:0] rsp;
    int err_count = 0, cmp_count = 0, cyc = 0;

    smb_ctrl #(.BOOST_DELAY_CYC(20), .SETTLE_CYC(10)) dut (
        .clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .cmpLow(cmpLow), .timeBaseReset(tbReset),
        .monitorOn(monOn), .thresholdSel(thrSel), .boostedSupplySel(boostSel),
        .logicSupplySel(logicSel), .biasRefPlain(biasPlain), .biasContrast(contrast), .irq(irq)
    );

    // Free-running 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end

    // Hang guard: a run this long means a handshake never came
    always @(posedge clk) begin
        cyc++;
        if (cyc >= LIMIT) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Address and data offered together, each dropped when taken, then wait for the response
    task automatic axiWrite(input logic [13:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic done;
        done = 1'b0;
        @(posedge clk);
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (awValid && awReady === 1'b1) awValid <= 1'b0;
            if (wValid && wReady === 1'b1) wValid <= 1'b0;
            if (bValid === 1'b1) begin
                resp = bResp;
                done = 1'b1;
            end
        end
        bReady <= 1'b0;
    endtask

    task automatic axiRead(input logic [13:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic done;
        done = 1'b0;
        @(posedge clk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (arValid && arReady === 1'b1) arValid <= 1'b0;
            if (rValid === 1'b1) begin
                d = rData;
                resp = rResp;
                done = 1'b1;
            end
        end
        rReady <= 1'b0;
    endtask

    task automatic wr(input logic [13:0] a, input logic [31:0] d);
        axiWrite(a, d, rsp);
        `CHK(rsp, smb_pkg::RESP_OKAY)
    endtask

    // Main sequence
    initial begin
        tick(16);
        rst_n <= 1'b1;
        tick(3);
        // Time-base reset still held: everything on the plain supply
        `CHK(boostSel, 1'b0)
        `CHK(biasPlain, 1'b1)
        `CHK(logicSel, 2'h0)
        tick(2);
        tbReset <= 1'b0;
        tick(3);
        `CHK(logicSel, 2'h1)
        `CHK(biasPlain, 1'b0)
        `CHK(boostSel, 1'b0)
        axiRead(A_SMC, rd, rsp);
        `CHK(rd, 32'h0)
        axiRead(A_BST, rd, rsp);
        `CHK(rd, 32'hf)
        tick(40);
        `CHK(boostSel, 1'b1)
        axiRead(A_STAT, rd, rsp);
        `CHK(rd[2], 1'b1)

        // Every threshold code; the written flag bit must not stick
        for (int i = 0; i < 4; i++) begin
            wr(A_SMC, 32'h8 | i);
            axiRead(A_SMC, rd, rsp);
            `CHK(rd, i)
            `CHK(thrSel, i[1:0])
        end

        // Detector stopped: flag stays low although the supply is low
        wr(A_MASK, 32'h1);
        cmpLow <= 1'b1;
        wr(A_SMC, 32'h3);
        tick(4);
        axiRead(A_SMC, rd, rsp);
        `CHK(rd, 32'h3)
        `CHK(monOn, 1'b0)
        // Enable, wait for settling, then the supply drops
        cmpLow <= 1'b0;
        wr(A_SMC, 32'h4);
        `CHK(monOn, 1'b1)
        rd = 32'h0;
        for (int k = 0; k < 20 && rd[1] !== 1'b1; k++) axiRead(A_STAT, rd, rsp);
        `CHK(rd[1], 1'b1)
        `CHK(irq, 1'b0)
        cmpLow <= 1'b1;
        tick(4);
        axiRead(A_SMC, rd, rsp);
        `CHK(rd, 32'hc)
        `CHK(irq, 1'b1)
        wr(A_STAT, 32'h1);
        tick(3);
        `CHK(irq, 1'b0)
        cmpLow <= 1'b0;
        tick(4);
        axiRead(A_SMC, rd, rsp);
        `CHK(rd, 32'h4)
        wr(A_SMC, 32'h0);
        `CHK(monOn, 1'b0)

        // Contrast and fast oscillator, then a time-base reset in mid-run
        wr(A_PWR, 32'h1a);
        tick(2);
        `CHK(contrast, 4'ha)
        `CHK(logicSel, 2'h2)
        tbReset <= 1'b1;
        tick(3);
        `CHK(logicSel, 2'h0)
        `CHK(biasPlain, 1'b1)
        `CHK(boostSel, 1'b0)
        tbReset <= 1'b0;
        wr(A_PWR, 32'h05);
        tick(2);
        `CHK(logicSel, 2'h1)
        `CHK(biasPlain, 1'b0)
        `CHK(contrast, 4'h5)
        tick(40);

        // Booster release drops the boosted selection one edge after the select bit clears
        // The only booster write of the run, as software is expected to do
        wr(A_BST, 32'h0);
        tick(1);
        `CHK(boostSel, 1'b0)
        axiRead(A_BST, rd, rsp);
        `CHK(rd, 32'he)

        // System reset in mid-run brings the register defaults back
        wr(A_SMC, 32'h7);
        rst_n <= 1'b0;
        tick(2);
        rst_n <= 1'b1;
        tick(2);
        axiRead(A_SMC, rd, rsp);
        `CHK(rd, 32'h0)
        axiRead(A_BST, rd, rsp);
        `CHK(rd, 32'hf)

        // Unmapped place answers with a decode error
        axiRead(A_NONE, rd, rsp);
        `CHK(rsp, smb_pkg::RESP_DECERR)
        `CHK(rd, 32'h0)
        axiWrite(A_NONE, 32'h1, rsp);
        `CHK(rsp, smb_pkg::RESP_DECERR)
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
